//--- pkg/raar_defs.svh
`ifndef RAAR_DEFS_SVH
`define RAAR_DEFS_SVH

// Alias entry offsets as seen through the register access port.
`define RAAR_ALIAS0_OFS     8'h65
`define RAAR_ALIAS3_OFS     8'h68
`define RAAR_ALIAS4_OFS     8'h69
`define RAAR_ALIAS5_OFS     8'h6A
`define RAAR_ALIAS6_OFS     8'h6B
`define RAAR_ALIAS7_OFS     8'h6C

// Field layout shared by alias and physical-address registers.
`define RAAR_ADDR_MSB       7
`define RAAR_ADDR_LSB       1
`define RAAR_AUTOACK_BIT    0

`define RAAR_ALIAS_RST      8'h00
`define RAAR_NUM_PORTS      2
`define RAAR_NUM_ENTRIES    8
`define RAAR_NUM_LOW        3
`define RAAR_NUM_LOCAL      5

`endif

//--- pkg/raar_pkg.sv
`include "raar_defs.svh"
package raar_pkg;

	typedef logic [7:0]                                   raar_byte_t;
	typedef logic [6:0]                                   raar_addr_t;
	typedef logic [2:0]                                   raar_idx_t;
	typedef logic [`RAAR_NUM_PORTS-1:0]                   raar_port_mask_t;
	typedef raar_byte_t [`RAAR_NUM_ENTRIES-1:0]           raar_table_t;
	typedef raar_byte_t [`RAAR_NUM_LOW-1:0]               raar_low_t;

	typedef enum logic {
		RAAR_IDLE  = 1'b0,
		RAAR_ROUTE = 1'b1
	} raar_state_t;

	function automatic raar_addr_t raar_field(raar_byte_t e);
		return e[`RAAR_ADDR_MSB:`RAAR_ADDR_LSB];
	endfunction : raar_field

	function automatic logic raar_live(raar_byte_t e);
		return |e[`RAAR_ADDR_MSB:`RAAR_ADDR_LSB];
	endfunction : raar_live

endpackage : raar_pkg

//--- src/raar_decoder.sv
`include "raar_defs.svh"
module raar_decoder (
	input  wire raar_pkg::raar_table_t entries,
	input  wire raar_pkg::raar_addr_t  addr,
	output logic                       hit,
	output raar_pkg::raar_idx_t        idx,
	output logic                       auto_ack
);
	import raar_pkg::*;

	// All eight comparators work at once; scanning from the top lets the
	// lowest matching index win when software programs duplicate aliases.
	always_comb begin
		hit      = 1'b0;
		idx      = 3'h0;
		auto_ack = 1'b0;
		for (int i = `RAAR_NUM_ENTRIES - 1; i >= 0; i--) begin
			if (raar_live(entries[i]) && raar_field(entries[i]) == addr) begin
				hit      = 1'b1;
				idx      = raar_idx_t'(i);
				auto_ack = entries[i][`RAAR_AUTOACK_BIT];
			end
		end
	end

endmodule : raar_decoder

//--- src/raar_top.sv
`include "raar_defs.svh"
module raar_top (
	input  wire logic                      SYS_CLK,
	input  wire logic                      RST,
	input  wire logic                      CLK_EN,
	input  wire logic                      REG_WR,
	input  wire logic                      REG_RD,
	input  wire raar_pkg::raar_byte_t      REG_ADDR,
	input  wire raar_pkg::raar_byte_t      REG_WDATA,
	input  wire logic                      RD_PORT,
	input  wire raar_pkg::raar_port_mask_t WR_PORT_EN,
	output raar_pkg::raar_byte_t           REG_RDATA,
	output logic                           REG_RDATA_VLD,
	output logic                           REG_HIT,
	input  wire raar_pkg::raar_low_t       ALIAS_LOW_P0,
	input  wire raar_pkg::raar_low_t       ALIAS_LOW_P1,
	input  wire raar_pkg::raar_table_t     PHYS_P0,
	input  wire raar_pkg::raar_table_t     PHYS_P1,
	input  wire logic                      ADDR_VLD,
	input  wire logic                      ADDR_PORT,
	input  wire raar_pkg::raar_addr_t      ADDR_IN,
	input  wire logic                      ADDR_RNW,
	output logic                           FWD_VLD,
	output logic                           FWD_HIT,
	output raar_pkg::raar_idx_t            FWD_IDX,
	output raar_pkg::raar_addr_t           FWD_ADDR,
	output logic                           FWD_RNW,
	input  wire logic                      BYTE_VLD,
	input  wire logic                      REMOTE_ACK,
	input  wire logic                      LINK_LOCKED,
	input  wire logic                      XFER_END,
	output logic                           ACK_VLD,
	output logic                           ACK
);
	import raar_pkg::*;

	// Register file: five local entries for each receive port.
	raar_byte_t  alias_tab      [`RAAR_NUM_PORTS][`RAAR_NUM_LOCAL];
	raar_byte_t  next_alias_tab [`RAAR_NUM_PORTS][`RAAR_NUM_LOCAL];
	raar_byte_t  rdata;
	raar_byte_t  next_rdata;
	logic        rdata_vld;
	logic        next_rdata_vld;
	logic        reg_hit;
	logic        next_reg_hit;

	// Transaction routing state.
	raar_state_t state;
	raar_state_t next_state;
	logic        fwd_vld;
	logic        next_fwd_vld;
	logic        fwd_hit;
	logic        next_fwd_hit;
	raar_idx_t   fwd_idx;
	raar_idx_t   next_fwd_idx;
	raar_addr_t  fwd_addr;
	raar_addr_t  next_fwd_addr;
	logic        fwd_rnw;
	logic        next_fwd_rnw;
	logic        auto_on;
	logic        next_auto_on;
	logic        ack_vld;
	logic        next_ack_vld;
	logic        ack;
	logic        next_ack;

	raar_table_t dec_table;
	raar_table_t phys_sel;
	logic        dec_hit;
	raar_idx_t   dec_idx;
	logic        dec_auto;

	function automatic logic is_local(raar_byte_t a);
		return a >= `RAAR_ALIAS3_OFS && a <= `RAAR_ALIAS7_OFS;
	endfunction : is_local

	function automatic logic [2:0] local_slot(raar_byte_t a);
		raar_byte_t d;
		d = a - `RAAR_ALIAS3_OFS;
		return d[2:0];
	endfunction : local_slot

	// Register access.
	always_comb begin
		next_alias_tab = alias_tab;
		next_rdata     = rdata;
		next_rdata_vld = 1'b0;
		next_reg_hit   = reg_hit;
		if (REG_WR && is_local(REG_ADDR)) begin
			for (int p = 0; p < `RAAR_NUM_PORTS; p++) begin
				if (WR_PORT_EN[p]) begin
					next_alias_tab[p][local_slot(REG_ADDR)] = REG_WDATA;
				end
			end
		end
		if (REG_RD) begin
			next_rdata_vld = 1'b1;
			next_reg_hit   = is_local(REG_ADDR);
			next_rdata     = is_local(REG_ADDR) ?
				alias_tab[RD_PORT][local_slot(REG_ADDR)] : 8'h00;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			for (int p = 0; p < `RAAR_NUM_PORTS; p++) begin
				for (int e = 0; e < `RAAR_NUM_LOCAL; e++) begin
					alias_tab[p][e] <= `RAAR_ALIAS_RST;
				end
			end
			rdata     <= 8'h00;
			rdata_vld <= 1'b0;
			reg_hit   <= 1'b0;
		end else if (CLK_EN) begin
			alias_tab <= next_alias_tab;
			rdata     <= next_rdata;
			rdata_vld <= next_rdata_vld;
			reg_hit   <= next_reg_hit;
		end
	end

	// Decoder table for the port the transaction arrived on.
	always_comb begin
		dec_table[`RAAR_NUM_LOW-1:0] = ADDR_PORT ? ALIAS_LOW_P1 : ALIAS_LOW_P0;
		for (int e = 0; e < `RAAR_NUM_LOCAL; e++) begin
			dec_table[e + `RAAR_NUM_LOW] = alias_tab[ADDR_PORT][e];
		end
		phys_sel = ADDR_PORT ? PHYS_P1 : PHYS_P0;
	end

	raar_decoder u_decoder (
		.entries  (dec_table),
		.addr     (ADDR_IN),
		.hit      (dec_hit),
		.idx      (dec_idx),
		.auto_ack (dec_auto)
	);

	// Routing: an address phase that hits opens a route, the end of transfer closes it.
	// A repeated start simply re-decodes, so a new address replaces the old route.
	always_comb begin
		next_state    = state;
		next_fwd_vld  = 1'b0;
		next_fwd_hit  = fwd_hit;
		next_fwd_idx  = fwd_idx;
		next_fwd_addr = fwd_addr;
		next_fwd_rnw  = fwd_rnw;
		next_auto_on  = auto_on;
		next_ack_vld  = 1'b0;
		next_ack      = 1'b0;
		case (state)
			RAAR_IDLE: begin
				next_auto_on = 1'b0;
			end
			RAAR_ROUTE: begin
				if (BYTE_VLD && !fwd_rnw) begin
					next_ack_vld = 1'b1;
					next_ack     = auto_on ? 1'b1 : (REMOTE_ACK && LINK_LOCKED);
				end
				if (XFER_END) begin
					next_state   = RAAR_IDLE;
					next_auto_on = 1'b0;
				end
			end
			default: begin
				next_state   = RAAR_IDLE;
				next_auto_on = 1'b0;
			end
		endcase
		if (ADDR_VLD) begin
			next_fwd_vld  = 1'b1;
			next_fwd_hit  = dec_hit;
			next_fwd_idx  = dec_idx;
			next_fwd_rnw  = ADDR_RNW;
			next_fwd_addr = dec_hit ? raar_field(phys_sel[dec_idx]) : ADDR_IN;
			next_auto_on  = dec_hit && dec_auto && !ADDR_RNW;
			next_state    = dec_hit ? RAAR_ROUTE : RAAR_IDLE;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			state    <= RAAR_IDLE;
			fwd_vld  <= 1'b0;
			fwd_hit  <= 1'b0;
			fwd_idx  <= 3'h0;
			fwd_addr <= 7'h00;
			fwd_rnw  <= 1'b0;
			auto_on  <= 1'b0;
			ack_vld  <= 1'b0;
			ack      <= 1'b0;
		end else if (CLK_EN) begin
			state    <= next_state;
			fwd_vld  <= next_fwd_vld;
			fwd_hit  <= next_fwd_hit;
			fwd_idx  <= next_fwd_idx;
			fwd_addr <= next_fwd_addr;
			fwd_rnw  <= next_fwd_rnw;
			auto_on  <= next_auto_on;
			ack_vld  <= next_ack_vld;
			ack      <= next_ack;
		end
	end

	assign REG_RDATA     = rdata;
	assign REG_RDATA_VLD = rdata_vld;
	assign REG_HIT       = reg_hit;
	assign FWD_VLD       = fwd_vld;
	assign FWD_HIT       = fwd_hit;
	assign FWD_IDX       = fwd_idx;
	assign FWD_ADDR      = fwd_addr;
	assign FWD_RNW       = fwd_rnw;
	assign ACK_VLD       = ack_vld;
	assign ACK           = ack;

endmodule : raar_top

//--- dv/raar_monitor.sv
module raar_monitor (
	input wire logic	SYS_CLK,
	input wire logic	RST,
	input wire logic	CLK_EN,
	input wire logic	REG_RD,
	input wire raar_pkg::raar_byte_t	REG_ADDR,
	input wire raar_pkg::raar_byte_t	REG_RDATA,
	input wire logic	REG_RDATA_VLD,
	input wire logic	REG_HIT,
	input wire raar_pkg::raar_table_t	PHYS_P0,
	input wire raar_pkg::raar_table_t	PHYS_P1,
	input wire logic	ADDR_VLD,
	input wire logic	ADDR_PORT,
	input wire raar_pkg::raar_addr_t	ADDR_IN,
	input wire logic	FWD_VLD,
	input wire logic	FWD_HIT,
	input wire raar_pkg::raar_idx_t	FWD_IDX,
	input wire raar_pkg::raar_addr_t	FWD_ADDR,
	input wire logic	BYTE_VLD,
	input wire logic	REMOTE_ACK,
	input wire logic	LINK_LOCKED,
	input wire logic	ACK_VLD,
	input wire logic	ACK
);
	timeunit 1ns;
	timeprecision 1ns;
	import raar_pkg::*;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	sequence s_dec; ADDR_VLD && CLK_EN; endsequence
	// A decode in the same cycle would reopen the route, so it is left out.
	sequence s_byte; BYTE_VLD && CLK_EN && !ADDR_VLD; endsequence
	a_read_answer: assert property (REG_RD && CLK_EN |=> REG_RDATA_VLD)
		else $error("read not answered");
	a_read_outside: assert property (REG_RD && CLK_EN && (REG_ADDR < 8'h68 || REG_ADDR > 8'h6C)
		|=> !REG_HIT && REG_RDATA == 8'h00) else $error("foreign read not empty");
	a_decode_answer: assert property (s_dec |=> FWD_VLD)
		else $error("decode not answered");
	a_zero_alias: assert property (s_dec ##0 ADDR_IN == 7'h00 |=> !FWD_HIT)
		else $error("zero alias matched");
	a_miss_echo: assert property (s_dec |=> FWD_HIT || FWD_ADDR == $past(ADDR_IN))
		else $error("miss address wrong");
	a_hit_remap: assert property (s_dec |=> !FWD_HIT || FWD_ADDR ==
		($past(ADDR_PORT) ? PHYS_P1[FWD_IDX][7:1] : PHYS_P0[FWD_IDX][7:1]))
		else $error("remap address wrong");
	a_lock_ack: assert property (ACK_VLD && $past(REMOTE_ACK && LINK_LOCKED) |-> ACK)
		else $error("good remote ack dropped");
	a_ack_idle: assert property (!ACK_VLD |-> !ACK)
		else $error("ack without valid");
	a_no_route: assert property (s_byte ##0 !FWD_HIT |=> !ACK_VLD)
		else $error("ack without route");
endmodule : raar_monitor

bind raar_top raar_monitor mon (.*);

//--- dv/raar_remote.sv
module raar_remote (
	input wire logic	clk,
	input wire logic	byte_vld,
	input wire logic	nak,
	output logic	remote_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	logic	idle_q = 1'b0;
	// Outside a byte the answer toggles so a stale value is never trusted.
	always @(posedge clk) idle_q <= ~idle_q;
	assign remote_ack = byte_vld ? ~nak : idle_q;
endmodule : raar_remote

//--- dv/test_raar_top.sv
module test_raar_top;
	timeunit 1ns;
	timeprecision 1ns;
	import raar_pkg::*;
	logic	sys_clk = 0, rst = 1, ce = 1, wr = 0, rd = 0, rp = 0, av = 0, ap = 0, rnw = 0;
	logic	bv = 0, lk = 0, nak = 0, xe = 0, rack, rv, rh, fv, fh, fr, kv, ack;
	raar_byte_t	addr = '0, wd = '0, rdata;
	raar_port_mask_t	wm = '0;
	raar_low_t	low0 = {8'h00, 8'hA0, 8'h00}, low1 = '0;
	raar_table_t	ph0, ph1;
	raar_addr_t	ain = '0, fa;
	raar_idx_t	fi;
	raar_byte_t	p0[5] = '{8'h60, 8'h43, 8'h60, 8'h01, 8'hFE};
	int	error_cnt = 0, n_checks = 0, cyc = 0;
	raar_top uut (.SYS_CLK(sys_clk), .RST(rst), .CLK_EN(ce), .REG_WR(wr), .REG_RD(rd),
		.REG_ADDR(addr), .REG_WDATA(wd), .RD_PORT(rp), .WR_PORT_EN(wm), .REG_RDATA(rdata),
		.REG_RDATA_VLD(rv), .REG_HIT(rh), .ALIAS_LOW_P0(low0), .ALIAS_LOW_P1(low1),
		.PHYS_P0(ph0), .PHYS_P1(ph1), .ADDR_VLD(av), .ADDR_PORT(ap), .ADDR_IN(ain),
		.ADDR_RNW(rnw), .FWD_VLD(fv), .FWD_HIT(fh), .FWD_IDX(fi), .FWD_ADDR(fa), .FWD_RNW(fr),
		.BYTE_VLD(bv), .REMOTE_ACK(rack), .LINK_LOCKED(lk), .XFER_END(xe), .ACK_VLD(kv), .ACK(ack));
	raar_remote peer (.clk(sys_clk), .byte_vld(bv), .nak(nak), .remote_ack(rack));
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input bit ok, input string m);
		n_checks++;
		if (!ok) begin
			error_cnt++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk
	task automatic reg_wr(input raar_byte_t a, input raar_byte_t d, input raar_port_mask_t m);
		@(negedge sys_clk) {addr, wd, wm, wr} = {a, d, m, 1'b1};
		@(negedge sys_clk) wr = 0;
	endtask : reg_wr
	task automatic reg_rd(input logic p, input raar_byte_t a, input raar_byte_t e, input logic h);
		@(negedge sys_clk) {rp, addr, rd} = {p, a, 1'b1};
		@(negedge sys_clk) rd = 0;
		chk(rv === 1'b1 && rdata === e && rh === h, "read mismatch");
	endtask : reg_rd
	task automatic dec(input logic p, input raar_addr_t a, input logic r, input logic h,
		input raar_idx_t i, input raar_addr_t e);
		@(negedge sys_clk) {ap, ain, rnw, av} = {p, a, r, 1'b1};
		@(negedge sys_clk) av = 0;
		chk(fv === 1'b1 && fh === h && fi === i && fa === e && fr === r, "decode mismatch");
	endtask : dec
	task automatic byt(input logic l, input logic n, input logic v, input logic k);
		@(negedge sys_clk) {lk, nak, bv} = {l, n, 1'b1};
		@(negedge sys_clk) bv = 0;
		chk(kv === v && ack === k, "ack mismatch");
	endtask : byt
	task automatic t_regs();
		for (int i = 0; i < 5; i++) begin
			reg_rd(1'b0, raar_byte_t'(8'h68 + i), 8'h00, 1'b1);
			reg_rd(1'b1, raar_byte_t'(8'h68 + i), 8'h00, 1'b1);
		end
		reg_wr(8'h68, 8'h99, 2'b11);
		reg_wr(8'h65, 8'h5A, 2'b11);
		reg_wr(8'h69, 8'h77, 2'b00);
		reg_rd(1'b1, 8'h68, 8'h99, 1'b1);
		reg_rd(1'b0, 8'h69, 8'h00, 1'b1);
		reg_rd(1'b0, 8'h65, 8'h00, 1'b0);
		reg_rd(1'b0, 8'h6D, 8'h00, 1'b0);
		for (int i = 0; i < 5; i++) begin
			reg_wr(raar_byte_t'(8'h68 + i), p0[i], 2'b01);
			reg_wr(raar_byte_t'(8'h68 + i), raar_byte_t'(8'h76 + 2 * i), 2'b10);
		end
		for (int i = 0; i < 5; i++) begin
			reg_rd(1'b0, raar_byte_t'(8'h68 + i), p0[i], 1'b1);
			reg_rd(1'b1, raar_byte_t'(8'h68 + i), raar_byte_t'(8'h76 + 2 * i), 1'b1);
		end
		$display("register test done");
	endtask : t_regs
	task automatic t_freeze();
		// With the enable low neither the write nor the read may be taken.
		@(negedge sys_clk) ce = 0;
		reg_wr(8'h68, 8'h55, 2'b01);
		@(negedge sys_clk) {addr, rd} = {8'h68, 1'b1};
		@(negedge sys_clk) rd = 0;
		ce = 1;
		chk(rv === 1'b0, "frozen read answered");
		reg_rd(1'b0, 8'h68, 8'h60, 1'b1);
		$display("clock enable test done");
	endtask : t_freeze
	task automatic t_decode();
		dec(1'b0, 7'h30, 1'b0, 1'b1, 3'h3, 7'h43);
		dec(1'b0, 7'h21, 1'b0, 1'b1, 3'h4, 7'h44);
		dec(1'b0, 7'h50, 1'b0, 1'b1, 3'h1, 7'h41);
		dec(1'b0, 7'h7F, 1'b0, 1'b1, 3'h7, 7'h47);
		dec(1'b0, 7'h00, 1'b0, 1'b0, 3'h0, 7'h00);
		dec(1'b0, 7'h11, 1'b0, 1'b0, 3'h0, 7'h11);
		dec(1'b1, 7'h3B, 1'b0, 1'b1, 3'h3, 7'h63);
		dec(1'b1, 7'h30, 1'b0, 1'b0, 3'h0, 7'h30);
		$display("decode test done");
	endtask : t_decode
	task automatic t_ack();
		dec(1'b0, 7'h21, 1'b0, 1'b1, 3'h4, 7'h44);
		byt(1'b0, 1'b1, 1'b1, 1'b1);
		byt(1'b1, 1'b1, 1'b1, 1'b1);
		@(negedge sys_clk) xe = 1;
		@(negedge sys_clk) xe = 0;
		byt(1'b1, 1'b0, 1'b0, 1'b0);
		dec(1'b0, 7'h30, 1'b0, 1'b1, 3'h3, 7'h43);
		byt(1'b1, 1'b0, 1'b1, 1'b1);
		byt(1'b1, 1'b1, 1'b1, 1'b0);
		byt(1'b0, 1'b0, 1'b1, 1'b0);
		dec(1'b0, 7'h21, 1'b1, 1'b1, 3'h4, 7'h44);
		byt(1'b1, 1'b0, 1'b0, 1'b0);
		dec(1'b0, 7'h11, 1'b0, 1'b0, 3'h0, 7'h11);
		byt(1'b1, 1'b0, 1'b0, 1'b0);
		$display("acknowledge test done");
	endtask : t_ack
	task automatic t_reset();
		// A reset in mid-run must clear entries that were written before it.
		@(negedge sys_clk) rst = 1;
		repeat (2) @(negedge sys_clk);
		rst = 0;
		chk(rv === 1'b0 && rh === 1'b0 && rdata === 8'h00 && fv === 1'b0, "reset outputs");
		chk(fh === 1'b0 && fi === 3'h0 && fa === 7'h00 && fr === 1'b0, "reset route");
		chk(kv === 1'b0 && ack === 1'b0, "reset ack");
		for (int i = 0; i < 5; i++) begin
			reg_rd(1'b0, raar_byte_t'(8'h68 + i), 8'h00, 1'b1);
			reg_rd(1'b1, raar_byte_t'(8'h68 + i), 8'h00, 1'b1);
		end
		dec(1'b0, 7'h30, 1'b0, 1'b0, 3'h0, 7'h30);
		$display("reset test done");
	endtask : t_reset
	initial begin
		for (int k = 0; k < 8; k++) begin
			ph0[k] = raar_byte_t'(8'h80 + 2 * k);
			ph1[k] = raar_byte_t'(8'hC0 + 2 * k);
		end
		repeat (8) @(negedge sys_clk);
		rst = 0;
		t_regs();
		t_freeze();
		t_decode();
		t_ack();
		t_reset();
		end_sim();
	end
endmodule : test_raar_top
